// file: logic/dmct_pkg.sv
// Constants for the dual counter/timer pair: register offsets, field
// positions, reset values and prescaler divide counts.
// Assumes a plain byte-wide register port driven by a single master.
package dmct_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_A_LOW = 4'h0; // Timer A count, low byte
  localparam logic [3:0] ADDR_A_HIGH = 4'h1; // Timer A count, high byte
  localparam logic [3:0] ADDR_B_LOW = 4'h2; // Timer B count, low byte
  localparam logic [3:0] ADDR_B_HIGH = 4'h3; // Timer B count, high byte
  localparam logic [3:0] ADDR_RUN_FLAG = 4'h4; // Run bits and overflow flags
  localparam logic [3:0] ADDR_MODE = 4'h5; // Mode, counter select, gate
  localparam logic [3:0] ADDR_CLK_SEL = 4'h6; // Clock select and prescale
  localparam logic [3:0] ADDR_EXT_CFG = 4'h7; // Gate polarity
  localparam logic [3:0] ADDR_IRQ_EN = 4'h8; // Interrupt enables

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  // Run/flag register
  localparam int RF_B_OVF = 7;
  localparam int RF_B_RUN = 6;
  localparam int RF_A_OVF = 5;
  localparam int RF_A_RUN = 4;
  // Mode register: timer B in the upper nibble, timer A in the lower
  localparam int MD_B_GATE = 7;
  localparam int MD_B_CSEL = 6;
  localparam int MD_B_MODE = 4;
  localparam int MD_A_GATE = 3;
  localparam int MD_A_CSEL = 2;
  localparam int MD_A_MODE = 0;
  // Clock select register
  localparam int CK_B_SYS = 3;
  localparam int CK_A_SYS = 2;
  localparam int CK_PRESCALE = 0;
  // External input configuration register
  localparam int EC_B_POL = 1;
  localparam int EC_A_POL = 0;
  // Interrupt enable register
  localparam int IE_B = 1;
  localparam int IE_A = 0;

  // ----------------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [1:0] PS_DIV12 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [1:0] PS_DIV48 = 2'h2;
  localparam logic [1:0] PS_EXT8 = 2'h3;

  // ----------------------------------------------------------------------
  // Prescaler divide counts
  // ----------------------------------------------------------------------
  localparam logic [5:0] DIV_12 = 6'h0c;
  localparam logic [5:0] DIV_4 = 6'h04;
  localparam logic [5:0] DIV_48 = 6'h30;
  localparam logic [5:0] DIV_EXT = 6'h08;

endpackage : dmct_pkg

// file: logic/dmct_timer_pair.sv
// Two counter/timers with four modes, shared prescaler, gating and
// overflow flags; registers reached over a plain byte-wide port.
// Assumes count, gate and external clock inputs are synchronous to clk_i
// but still resamples them; one system clock drives everything.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module dmct_timer_pair (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // External pins
  input wire logic timer_a_count_pin_i,
  input wire logic timer_b_count_pin_i,
  input wire logic timer_a_gate_input_i,
  input wire logic timer_b_gate_input_i,
  input wire logic ext_clk_i,
  // Interrupt acknowledges from the interrupt logic
  input wire logic irq_a_ack_i,
  input wire logic irq_b_ack_i,
  // Interrupt requests and timer B overflow for baud and conversion use
  output logic irq_a_o,
  output logic irq_b_o,
  output logic timer_b_ovf_pulse_o
);
  import dmct_pkg::*;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] a_low_ff, a_high_ff, b_low_ff, b_high_ff;
  logic [7:0] run_flag_ff, mode_ff, clk_sel_ff, ext_cfg_ff, irq_en_ff;
  logic [7:0] nxt_a_low, nxt_a_high, nxt_b_low, nxt_b_high;
  logic [7:0] rdata_ff;
  logic b_ovf_ff;

  // Decoded controls
  logic [1:0] mode_a, mode_b;
  logic split;
  assign mode_a = mode_ff[MD_A_MODE +: 2];
  assign mode_b = mode_ff[MD_B_MODE +: 2];
  assign split = (mode_a == MODE_SPLIT);

  // ----------------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------------
  // Stage 1 feeds only stage 2; stage 3 holds the previous level
  logic [4:0] sync1_ff, sync2_ff, sync3_ff;
  logic [4:0] raw_in;
  assign raw_in = {ext_clk_i, timer_b_gate_input_i, timer_a_gate_input_i,
                   timer_b_count_pin_i, timer_a_count_pin_i};

  // Two-stage synchroniser plus one delay for edges
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      sync3_ff <= 5'h00;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  logic fall_a, fall_b, ext_fall;
  assign fall_a = sync3_ff[0] & ~sync2_ff[0];
  assign fall_b = sync3_ff[1] & ~sync2_ff[1];
  assign ext_fall = sync3_ff[4] & ~sync2_ff[4];

  // Gate active level follows polarity bit
  logic gate_a_act, gate_b_act;
  assign gate_a_act = (sync2_ff[2] == ext_cfg_ff[EC_A_POL]);
  assign gate_b_act = (sync2_ff[3] == ext_cfg_ff[EC_B_POL]);

  // ----------------------------------------------------------------------
  // Shared prescaler
  // ----------------------------------------------------------------------
  logic [5:0] ps_cnt_ff, ps_div;
  logic ps_tick;
  always_comb begin
    unique case (clk_sel_ff[CK_PRESCALE +: 2])
      PS_DIV12: ps_div = DIV_12;
      PS_DIV4: ps_div = DIV_4;
      PS_DIV48: ps_div = DIV_48;
      PS_EXT8: ps_div = DIV_EXT;
    endcase
  end
  // External mode counts synchronised falling edges, others every clock
  logic ps_step;
  assign ps_step = (clk_sel_ff[CK_PRESCALE +: 2] == PS_EXT8) ? ext_fall
                                                             : 1'b1;
  assign ps_tick = ps_step && (ps_cnt_ff >= ps_div - 6'h01);

  // Prescale divider, one-cycle tick per period
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ps_cnt_ff <= 6'h00;
    end else if (ps_tick) begin
      ps_cnt_ff <= 6'h00;
    end else if (ps_step) begin
      ps_cnt_ff <= ps_cnt_ff + 6'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Count enables
  // ----------------------------------------------------------------------
  logic tick_a, tick_b, tick_ah, run_a, run_b, en_a, en_b, en_ah;
  // Counter select picks the pin, else system or prescaled clock
  assign tick_a = mode_ff[MD_A_CSEL] ? fall_a
                : (clk_sel_ff[CK_A_SYS] | ps_tick);
  // Timer B never takes pin edges while A is split
  assign tick_b = (mode_ff[MD_B_CSEL] && !split) ? fall_b
                : (clk_sel_ff[CK_B_SYS] | ps_tick);
  assign tick_ah = clk_sel_ff[CK_A_SYS] | ps_tick;
  assign run_a = run_flag_ff[RF_A_RUN] &&
                 (!mode_ff[MD_A_GATE] || gate_a_act);
  // In split mode B runs by its mode field only
  assign run_b = split ? (mode_b != MODE_SPLIT)
               : (run_flag_ff[RF_B_RUN] && (mode_b != MODE_SPLIT) &&
                  (!mode_ff[MD_B_GATE] || gate_b_act));
  assign en_a = run_a && tick_a;
  assign en_b = run_b && tick_b;
  assign en_ah = split && run_flag_ff[RF_B_RUN] && tick_ah;

  // ----------------------------------------------------------------------
  // Counting per timer
  // ----------------------------------------------------------------------
  logic ovf_a, ovf_b, ovf_ah;

  // Next count for one timer by mode; returns {ovf, high, low}
  function automatic logic [16:0] step(input logic [1:0] md,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [12:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    c13 = {hi, lo[4:0]} + 13'h0001;
    c16 = {1'b0, hi, lo} + 17'h00001;
    c8 = {1'b0, lo} + 9'h001;
    step = {1'b0, hi, lo};
    unique case (md)
      MODE_13BIT: step = {({hi, lo[4:0]} == 13'h1fff), c13[12:5],
                          lo[7:5], c13[4:0]};
      MODE_16BIT: step = c16;
      // Reload byte is never written here
      MODE_RELOAD: step = c8[8] ? {1'b1, hi, hi}
                                : {1'b0, hi, c8[7:0]};
      MODE_SPLIT: step = {c8[8], hi, c8[7:0]};
    endcase
  endfunction : step

  logic [16:0] res_a, res_b;
  logic [8:0] res_ah;
  assign res_a = step(mode_a, a_low_ff, a_high_ff);
  assign res_b = step(mode_b, b_low_ff, b_high_ff);
  assign res_ah = {1'b0, a_high_ff} + 9'h001;
  assign ovf_a = en_a && res_a[16];
  assign ovf_b = en_b && res_b[16];
  assign ovf_ah = en_ah && res_ah[8];

  // Next values: a register write wins over counting
  always_comb begin
    nxt_a_low = a_low_ff;
    nxt_a_high = a_high_ff;
    nxt_b_low = b_low_ff;
    nxt_b_high = b_high_ff;
    if (en_a) begin
      nxt_a_low = res_a[7:0];
      if (!split) begin
        nxt_a_high = res_a[15:8];
      end
    end
    if (en_ah) begin
      nxt_a_high = res_ah[7:0];
    end
    if (en_b) begin
      nxt_b_low = res_b[7:0];
      nxt_b_high = res_b[15:8];
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_A_LOW: nxt_a_low = reg_wdata_i;
        ADDR_A_HIGH: nxt_a_high = reg_wdata_i;
        ADDR_B_LOW: nxt_b_low = reg_wdata_i;
        ADDR_B_HIGH: nxt_b_high = reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Count registers; run bit changes never touch them
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_low_ff <= RESET_BYTE;
      a_high_ff <= RESET_BYTE;
      b_low_ff <= RESET_BYTE;
      b_high_ff <= RESET_BYTE;
    end else begin
      a_low_ff <= nxt_a_low;
      a_high_ff <= nxt_a_high;
      b_low_ff <= nxt_b_low;
      b_high_ff <= nxt_b_high;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic set_fa, set_fb;
  assign set_fa = ovf_a;
  assign set_fb = split ? ovf_ah : ovf_b;

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_ff <= RESET_BYTE;
      clk_sel_ff <= RESET_BYTE;
      ext_cfg_ff <= RESET_BYTE;
      irq_en_ff <= RESET_BYTE;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_MODE) mode_ff <= reg_wdata_i;
      if (reg_addr_i == ADDR_CLK_SEL) clk_sel_ff <= {4'h0, reg_wdata_i[3:0]};
      if (reg_addr_i == ADDR_EXT_CFG) ext_cfg_ff <= {6'h00, reg_wdata_i[1:0]};
      if (reg_addr_i == ADDR_IRQ_EN) irq_en_ff <= {6'h00, reg_wdata_i[1:0]};
    end
  end

  // Run bits and sticky overflow flags; a set beats a clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      run_flag_ff <= RESET_BYTE;
    end else begin
      if (reg_wr_i && reg_addr_i == ADDR_RUN_FLAG) begin
        run_flag_ff <= {reg_wdata_i[7:4], 4'h0};
      end else begin
        if (irq_a_ack_i) run_flag_ff[RF_A_OVF] <= 1'b0;
        if (irq_b_ack_i) run_flag_ff[RF_B_OVF] <= 1'b0;
      end
      if (set_fa) run_flag_ff[RF_A_OVF] <= 1'b1;
      if (set_fb) run_flag_ff[RF_B_OVF] <= 1'b1;
    end
  end

  // Timer B overflow pulse, kept even while A is split
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      b_ovf_ff <= 1'b0;
    end else begin
      b_ovf_ff <= ovf_b;
    end
  end
  assign timer_b_ovf_pulse_o = b_ovf_ff;

  // Interrupt requests gated by each timer's own enable
  assign irq_a_o = run_flag_ff[RF_A_OVF] & irq_en_ff[IE_A];
  assign irq_b_o = run_flag_ff[RF_B_OVF] & irq_en_ff[IE_B];

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Data stands one cycle after the read strobe, zero otherwise
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= RESET_BYTE;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_A_LOW: rdata_ff <= a_low_ff;
        ADDR_A_HIGH: rdata_ff <= a_high_ff;
        ADDR_B_LOW: rdata_ff <= b_low_ff;
        ADDR_B_HIGH: rdata_ff <= b_high_ff;
        ADDR_RUN_FLAG: rdata_ff <= run_flag_ff;
        ADDR_MODE: rdata_ff <= mode_ff;
        ADDR_CLK_SEL: rdata_ff <= clk_sel_ff;
        ADDR_EXT_CFG: rdata_ff <= ext_cfg_ff;
        ADDR_IRQ_EN: rdata_ff <= irq_en_ff;
        default: rdata_ff <= RESET_BYTE;
      endcase
    end else begin
      rdata_ff <= RESET_BYTE;
    end
  end
  assign reg_rdata_o = rdata_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_mode0_wrap_flag: assert property (
    (en_a && mode_a == MODE_13BIT && a_high_ff == 8'hff &&
     a_low_ff[4:0] == 5'h1f) |=> run_flag_ff[RF_A_OVF] &&
     a_high_ff == 8'h00 && a_low_ff[4:0] == 5'h00)
    else $error("mode 0 wrap did not set flag or clear count");
  a_reload_low_byte: assert property (
    (en_a && mode_a == MODE_RELOAD && a_low_ff == 8'hff && !reg_wr_i)
    |=> a_low_ff == $past(a_high_ff) && run_flag_ff[RF_A_OVF])
    else $error("mode 2 reload missed");
  a_reload_high_kept: assert property (
    (mode_a == MODE_RELOAD && !split && !reg_wr_i) |=> $stable(a_high_ff))
    else $error("mode 2 reload byte changed");
  a_halt_holds: assert property (
    (!run_a && !split && !reg_wr_i) |=> $stable(a_low_ff) &&
    $stable(a_high_ff))
    else $error("timer A moved while halted");
  // An enabled overflow must reach the request line on the next cycle
  a_irq_gated: assert property (
    (ovf_a && irq_en_ff[IE_A] && !reg_wr_i) |=> irq_a_o)
    else $error("timer A overflow gave no interrupt request");
  a_flag_sticky: assert property (
    (run_flag_ff[RF_A_OVF] && !reg_wr_i && !irq_a_ack_i)
    |=> run_flag_ff[RF_A_OVF])
    else $error("overflow flag dropped");
  a_split_b_flag: assert property (
    (split && !ovf_ah && !reg_wr_i && !run_flag_ff[RF_B_OVF])
    |=> !run_flag_ff[RF_B_OVF])
    else $error("timer B flag set while A is split");
  a_b_halt_mode3: assert property (
    (mode_b == MODE_SPLIT && !reg_wr_i) |=> $stable(b_low_ff) &&
    $stable(b_high_ff))
    else $error("timer B counted in mode 3");
  a_pin_edge_count: assert property (
    (mode_ff[MD_A_CSEL] && run_a && fall_a && mode_a == MODE_16BIT &&
     !reg_wr_i) |=> {a_high_ff, a_low_ff} ==
     16'({$past(a_high_ff), $past(a_low_ff)} + 16'h0001))
    else $error("falling pin edge not counted");

  c_mode0_wrap: cover property (ovf_a && mode_a == MODE_13BIT);
  c_reload_wrap: cover property (ovf_a && mode_a == MODE_RELOAD);
  c_split_high: cover property (ovf_ah);
  c_gated_count: cover property (en_a && mode_ff[MD_A_GATE]);

endmodule : dmct_timer_pair

// file: tb/tb_dmct_timer_pair.sv
// Self-checking bench for the dual counter/timer pair: register access
// through the byte port, pin-driven counting, gating, modes and prescaler.
// Assumes the design holds its own assertions; one 250 MHz clock.
`timescale 1ns/1ns
module tb_dmct_timer_pair;
  import dmct_pkg::*;

  // --------------------------------------------------------------------
  // Signals and counters
  // --------------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic pin_a = 1'b1;
  logic pin_b = 1'b1;
  logic gate_a = 1'b0;
  logic gate_b = 1'b0;
  logic ext_clk = 1'b1;
  logic [1:0] ext_div = 2'h0;
  logic ack_a = 1'b0;
  logic ack_b = 1'b0;
  logic irq_a_o;
  logic irq_b_o;
  logic b_ovf_pulse;
  int err_total = 0;
  int samples_checked = 0;
  int b_ovf_seen = 0;
  logic [7:0] v0;
  logic [7:0] v1;

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("Error at %0t: got %h want %h", $time, (g), (e)); \
  end end

  // Clock, external clock at a quarter rate, overflow pulse counter
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ext_div <= ext_div + 2'h1;
    ext_clk <= ext_div[1];
    if (b_ovf_pulse === 1'b1) b_ovf_seen <= b_ovf_seen + 1;
  end

  dmct_timer_pair i_dmct_timer_pair (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .timer_a_count_pin_i(pin_a),
    .timer_b_count_pin_i(pin_b),
    .timer_a_gate_input_i(gate_a),
    .timer_b_gate_input_i(gate_b),
    .ext_clk_i(ext_clk),
    .irq_a_ack_i(ack_a),
    .irq_b_ack_i(ack_b),
    .irq_a_o(irq_a_o),
    .irq_b_o(irq_b_o),
    .timer_b_ovf_pulse_o(b_ovf_pulse)
  );

  // --------------------------------------------------------------------
  // Bus and pin tasks
  // --------------------------------------------------------------------
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd

  // Read and compare in one call
  task automatic expect_reg(input logic [3:0] a, input logic [7:0] m,
                            input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d & m, e)
  endtask : expect_reg

  // Falling edges on a count pin, each level held three clocks
  task automatic pulse(input int which, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      if (which == 0) pin_a <= 1'b0; else pin_b <= 1'b0;
      repeat (3) @(posedge clk_i);
      if (which == 0) pin_a <= 1'b1; else pin_b <= 1'b1;
      repeat (2) @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
  endtask : pulse

  // Gate level change, then let the synchroniser settle
  task automatic set_gate(input logic g);
    @(posedge clk_i);
    gate_a <= g;
    repeat (4) @(posedge clk_i);
  endtask : set_gate

  // Low byte advance over a gap that spans whole clock periods
  task automatic rate(input logic [7:0] ck, input int gap);
    wr(ADDR_CLK_SEL, ck);
    repeat (100) @(posedge clk_i);
    rd(ADDR_A_LOW, v0);
    repeat (gap - 2) @(posedge clk_i);
    rd(ADDR_A_LOW, v1);
    `CHK(8'(v1 - v0), 8'h0a)
  endtask : rate

  task automatic stop_test;
    $display("Counts: %0d compared, %0d mismatched", samples_checked,
             err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // --------------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    stop_test();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    int k;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Reset values, unmapped place, read-only low bits of run/flag
    for (int a = 0; a < 10; a++) expect_reg(4'(a), 8'hff, 8'h00);
    wr(4'h9, 8'h5a);
    expect_reg(4'h9, 8'hff, 8'h00);
    wr(ADDR_RUN_FLAG, 8'h0f);
    expect_reg(ADDR_RUN_FLAG, 8'hff, 8'h00);
    $display("test reset done");
    // Clock sources: system clock and every prescale code
    wr(ADDR_MODE, {6'h00, MODE_16BIT});
    wr(ADDR_RUN_FLAG, 8'h10);
    rate(8'h04, 10);
    rate({6'h00, PS_DIV12}, 120);
    rate({6'h00, PS_DIV4}, 40);
    rate({6'h00, PS_DIV48}, 480);
    rate({6'h00, PS_EXT8}, 320);
    wr(ADDR_RUN_FLAG, 8'h00);
    $display("test clock sources done");
    // 13-bit count from the pin, wrap, flag, enable and acknowledge
    wr(ADDR_MODE, 8'h04);
    wr(ADDR_A_LOW, 8'h1d);
    wr(ADDR_A_HIGH, 8'hff);
    wr(ADDR_RUN_FLAG, 8'h10);
    expect_reg(ADDR_A_LOW, 8'h1f, 8'h1d);
    pulse(0, 2);
    expect_reg(ADDR_A_LOW, 8'h1f, 8'h1f);
    expect_reg(ADDR_A_HIGH, 8'hff, 8'hff);
    pulse(0, 1);
    expect_reg(ADDR_A_LOW, 8'h1f, 8'h00);
    expect_reg(ADDR_A_HIGH, 8'hff, 8'h00);
    expect_reg(ADDR_RUN_FLAG, 8'hff, 8'h30);
    `CHK(irq_a_o, 1'b0)
    wr(ADDR_IRQ_EN, 8'h01);
    #1 `CHK(irq_a_o, 1'b1)
    @(posedge clk_i) ack_a <= 1'b1;
    @(posedge clk_i) ack_a <= 1'b0;
    expect_reg(ADDR_RUN_FLAG, 8'hff, 8'h10);
    `CHK(irq_a_o, 1'b0)
    $display("test 13-bit done");
    // Gating with both polarities, then run bit off
    wr(ADDR_MODE, 8'h0d);
    wr(ADDR_A_LOW, 8'h00);
    wr(ADDR_EXT_CFG, 8'h01);
    set_gate(1'b0);
    pulse(0, 2);
    expect_reg(ADDR_A_LOW, 8'hff, 8'h00);
    set_gate(1'b1);
    pulse(0, 2);
    expect_reg(ADDR_A_LOW, 8'hff, 8'h02);
    wr(ADDR_EXT_CFG, 8'h00);
    pulse(0, 1);
    expect_reg(ADDR_A_LOW, 8'hff, 8'h02);
    set_gate(1'b0);
    pulse(0, 1);
    expect_reg(ADDR_A_LOW, 8'hff, 8'h03);
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_RUN_FLAG, 8'h00);
    pulse(0, 1);
    expect_reg(ADDR_A_LOW, 8'hff, 8'h03);
    $display("test gate done");
    // Timer B auto-reload from its pin, timer A left idle
    k = b_ovf_seen;
    wr(ADDR_MODE, 8'h64);
    wr(ADDR_B_LOW, 8'hfe);
    wr(ADDR_B_HIGH, 8'h80);
    wr(ADDR_IRQ_EN, 8'h00);
    wr(ADDR_RUN_FLAG, 8'h40);
    pulse(1, 3);
    expect_reg(ADDR_B_LOW, 8'hff, 8'h81);
    expect_reg(ADDR_B_HIGH, 8'hff, 8'h80);
    expect_reg(ADDR_RUN_FLAG, 8'hff, 8'hc0);
    expect_reg(ADDR_A_LOW, 8'hff, 8'h03);
    `CHK(b_ovf_seen - k, 1)
    `CHK(irq_b_o, 1'b0)
    wr(ADDR_IRQ_EN, 8'h02);
    #1 `CHK(irq_b_o, 1'b1)
    `CHK(irq_a_o, 1'b0)
    @(posedge clk_i) ack_b <= 1'b1;
    @(posedge clk_i) ack_b <= 1'b0;
    expect_reg(ADDR_RUN_FLAG, 8'hff, 8'h40);
    // Timer B gated by its own input, active low
    wr(ADDR_MODE, 8'he4);
    @(posedge clk_i) gate_b <= 1'b1;
    pulse(1, 1);
    expect_reg(ADDR_B_LOW, 8'hff, 8'h81);
    @(posedge clk_i) gate_b <= 1'b0;
    pulse(1, 1);
    expect_reg(ADDR_B_LOW, 8'hff, 8'h82);
    // Timer A auto-reload on the system clock, wrap in the first cycle
    wr(ADDR_MODE, 8'h62);
    wr(ADDR_CLK_SEL, 8'h04);
    wr(ADDR_A_HIGH, 8'hf0);
    wr(ADDR_A_LOW, 8'hff);
    wr(ADDR_RUN_FLAG, 8'h50);
    wr(ADDR_IRQ_EN, 8'h03);
    #1 `CHK(irq_a_o, 1'b1)
    wr(ADDR_RUN_FLAG, 8'h40);
    expect_reg(ADDR_A_LOW, 8'hff, 8'hf3);
    expect_reg(ADDR_A_HIGH, 8'hff, 8'hf0);
    $display("test reload done");
    // Split mode: A low on the pin, A high on clocks under B run
    wr(ADDR_RUN_FLAG, 8'h00);
    wr(ADDR_MODE, 8'h57);
    wr(ADDR_CLK_SEL, 8'h04);
    wr(ADDR_A_LOW, 8'hfe);
    wr(ADDR_A_HIGH, 8'h00);
    wr(ADDR_IRQ_EN, 8'h03);
    wr(ADDR_RUN_FLAG, 8'h10);
    pulse(0, 2);
    pulse(1, 3);
    expect_reg(ADDR_A_LOW, 8'hff, 8'h00);
    expect_reg(ADDR_A_HIGH, 8'hff, 8'h00);
    expect_reg(ADDR_RUN_FLAG, 8'hff, 8'h30);
    rd(ADDR_B_LOW, v0);
    repeat (118) @(posedge clk_i);
    rd(ADDR_B_LOW, v1);
    `CHK(8'(v1 - v0), 8'h0a)
    wr(ADDR_RUN_FLAG, 8'h50);
    k = 0;
    while (irq_b_o !== 1'b1 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 400) begin
      err_total++;
      stop_test();
    end
    `CHK(irq_b_o, 1'b1)
    wr(ADDR_MODE, 8'h77);
    rd(ADDR_B_LOW, v0);
    repeat (118) @(posedge clk_i);
    rd(ADDR_B_LOW, v1);
    `CHK(v1, v0)
    $display("test split done");
    stop_test();
  end

endmodule : tb_dmct_timer_pair
